// ==== hw/port_bus_host.sv ====
// Operation
// - select msb is bit 2; refuse 6,7
// - read_write high reads, low writes
// - write data before enabling direction
// - hold write data while write active
`timescale 1ns/1ps
`default_nettype none
module port_bus_host
    import port_ctrl_pkg::*;
#(
    parameter int WIDTH = DATA_W
) (
    input wire logic clock,
    input wire logic rst,
    // user side
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [2:0] req_reg,
    input wire logic [WIDTH-1:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic rsp_error,
    output logic [WIDTH-1:0] rsp_rdata,
    // device side
    output logic chip_select_n,
    output logic read_write,
    output logic [2:0] register_select,
    output logic [WIDTH-1:0] host_data_bus_out,
    output logic host_data_bus_oe,
    input wire logic [WIDTH-1:0] host_data_bus_in,
    output logic reset_n
);
    localparam logic [CNT_W-1:0] WA_CNT = CNT_W'(WRITE_ACTIVE_CYC);
    // read window also spans the two synchroniser stages, so the word taken
    // was sampled on the pins a full access time after the select settled
    localparam logic [CNT_W-1:0] ACC_CNT = CNT_W'(ACCESS_CYC + SYNC_STAGES);
    localparam logic [CNT_W-1:0] CYC_CNT = CNT_W'(CYCLE_CYC);
    localparam logic [CNT_W-1:0] SU_CNT = CNT_W'(SETUP_CYC);

    // legal register code check
    function automatic logic legal_code(input logic [2:0] code);
        legal_code = (code <= REG_LAST_LEGAL);
    endfunction : legal_code

    // ----------------------------------------
    // bus input synchroniser
    // ----------------------------------------
    logic [WIDTH-1:0] sync1_ff, sync2_ff, nxt_sync1, nxt_sync2;
    always_comb begin
        nxt_sync1 = host_data_bus_in;
        nxt_sync2 = sync1_ff;
    end
    always_ff @(posedge clock) begin
        sync1_ff <= nxt_sync1;
        sync2_ff <= nxt_sync2;
    end

    // ----------------------------------------
    // access sequencer
    // ----------------------------------------
    bus_state_t state_ff, nxt_state;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic write_ff, nxt_write;
    logic [2:0] sel_ff, nxt_sel;
    logic [WIDTH-1:0] dout_ff, nxt_dout;
    logic oe_ff, nxt_oe;
    logic cs_n_ff, nxt_cs_n;
    logic rw_ff, nxt_rw;
    logic ready_ff, nxt_ready;
    logic rvalid_ff, nxt_rvalid;
    logic rerr_ff, nxt_rerr;
    logic [WIDTH-1:0] rdata_ff, nxt_rdata;
    logic rstn_ff, nxt_rstn;

    // next-state logic; strobes are placed only after address settles
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_write = write_ff;
        nxt_sel = sel_ff;
        nxt_dout = dout_ff;
        nxt_oe = oe_ff;
        nxt_cs_n = cs_n_ff;
        nxt_rw = rw_ff;
        nxt_ready = 1'b0;
        nxt_rvalid = 1'b0;
        nxt_rerr = 1'b0;
        nxt_rdata = rdata_ff;
        nxt_rstn = 1'b1;
        case (state_ff)
            ST_IDLE: begin
                nxt_ready = 1'b1;
                if (req_valid && ready_ff) begin
                    nxt_ready = 1'b0;
                    if (!legal_code(req_reg)) begin
                        nxt_rvalid = 1'b1; // codes 6 and 7 never reach the pins
                        nxt_rerr = 1'b1;
                    end else begin
                        nxt_state = ST_SETUP;
                        nxt_cnt = SU_CNT;
                        nxt_write = req_write;
                        nxt_sel = req_reg; // bit 2 is the msb
                        nxt_dout = req_wdata;
                        nxt_rw = !req_write; // high read, low write
                        nxt_oe = req_write; // drive only for writes
                    end
                end
            end
            ST_SETUP: begin
                nxt_cnt = cnt_ff - 1'b1;
                if (cnt_ff <= 1) begin
                    nxt_state = ST_ACTIVE;
                    nxt_cs_n = 1'b0; // device responds only now
                    nxt_cnt = write_ff ? WA_CNT : ACC_CNT;
                end
            end
            ST_ACTIVE: begin
                nxt_cnt = cnt_ff - 1'b1;
                if (cnt_ff <= 1) begin
                    nxt_state = ST_HOLD;
                    nxt_cs_n = 1'b1; // rising select ends write, device latches
                    nxt_cnt = SU_CNT;
                    if (!write_ff) begin
                        nxt_rdata = sync2_ff; // sensed pin levels or direction
                    end
                end
            end
            ST_HOLD: begin
                // data held past select release
                nxt_cnt = cnt_ff - 1'b1;
                if (cnt_ff <= 1) begin
                    nxt_state = ST_RECOVER;
                    nxt_oe = 1'b0;
                    nxt_rw = 1'b1;
                    nxt_rvalid = 1'b1;
                    nxt_cnt = CYC_CNT;
                end
            end
            ST_RECOVER: begin
                nxt_cnt = cnt_ff - 1'b1;
                if (cnt_ff <= 1) begin
                    nxt_state = ST_IDLE;
                    nxt_ready = 1'b1;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
                nxt_cs_n = 1'b1;
                nxt_oe = 1'b0;
            end
        endcase
        if (rst) begin
            nxt_rstn = 1'b0; // device clears all registers
        end
    end

    // registers only
    always_ff @(posedge clock) begin
        if (rst) begin
            state_ff <= ST_IDLE;
            cnt_ff <= '0;
            write_ff <= 1'b0;
            sel_ff <= 3'h0;
            dout_ff <= '0;
            oe_ff <= 1'b0;
            cs_n_ff <= 1'b1;
            rw_ff <= 1'b1;
            ready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rerr_ff <= 1'b0;
            rdata_ff <= '0;
            rstn_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            write_ff <= nxt_write;
            sel_ff <= nxt_sel;
            dout_ff <= nxt_dout;
            oe_ff <= nxt_oe;
            cs_n_ff <= nxt_cs_n;
            rw_ff <= nxt_rw;
            ready_ff <= nxt_ready;
            rvalid_ff <= nxt_rvalid;
            rerr_ff <= nxt_rerr;
            rdata_ff <= nxt_rdata;
            rstn_ff <= nxt_rstn;
        end
    end

    // direction policy is software's job: write data first
    // direction bits map 1:1 to pins in the device
    assign chip_select_n = cs_n_ff;
    assign read_write = rw_ff;
    assign register_select = sel_ff;
    assign host_data_bus_out = dout_ff;
    assign host_data_bus_oe = oe_ff;
    assign req_ready = ready_ff;
    assign rsp_valid = rvalid_ff;
    assign rsp_error = rerr_ff;
    assign rsp_rdata = rdata_ff;
    assign reset_n = rstn_ff;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    sequence write_low_s;
        !chip_select_n && !read_write;
    endsequence
    no_illegal_sel_a: assert property (@(posedge clock) disable iff (rst)
        !chip_select_n |-> legal_code(register_select))
        else $error("illegal register code on bus");
    write_drive_a: assert property (@(posedge clock) disable iff (rst)
        write_low_s |-> host_data_bus_oe && $stable(host_data_bus_out))
        else $error("write data not held");
    read_float_a: assert property (@(posedge clock) disable iff (rst)
        read_write |-> !host_data_bus_oe)
        else $error("host drives bus during read");
    write_len_a: assert property (@(posedge clock) disable iff (rst)
        $fell(chip_select_n) && !read_write |-> write_low_s [*8])
        else $error("write active too short");
    sel_stable_a: assert property (@(posedge clock) disable iff (rst)
        !chip_select_n |-> $stable(register_select) && $stable(read_write))
        else $error("select or direction moved during access");
    reset_out_a: assert property (@(posedge clock)
        rst |=> !reset_n && chip_select_n)
        else $error("device reset not asserted");

    // write-active length monitor; a counter covers the whole window where
    // a long repetition would be too costly to unroll
    logic [CNT_W-1:0] wa_run_ff, nxt_wa_run;
    always_comb begin
        nxt_wa_run = '0;
        if (!chip_select_n && !read_write) begin
            nxt_wa_run = wa_run_ff + 1'b1;
        end
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            wa_run_ff <= '0;
        end else begin
            wa_run_ff <= nxt_wa_run;
        end
    end
    wa_count_a: assert property (@(posedge clock) disable iff (rst)
        $rose(chip_select_n) && !read_write |-> wa_run_ff >= WA_CNT)
        else $error("write active window shorter than minimum");
endmodule : port_bus_host
`default_nettype wire

// ==== hw/port_ctrl_pkg.sv ====
package port_ctrl_pkg;
    // ----------------------------------------
    // register map of the device outside
    // ----------------------------------------
    localparam logic [2:0] REG_PORT_A_DATA = 3'h0;
    localparam logic [2:0] REG_PORT_B_DATA = 3'h1;
    localparam logic [2:0] REG_PORT_C_DATA = 3'h2;
    localparam logic [2:0] REG_PORT_A_DIRECTION = 3'h3;
    localparam logic [2:0] REG_PORT_B_DIRECTION = 3'h4;
    localparam logic [2:0] REG_PORT_C_DIRECTION = 3'h5;
    localparam logic [2:0] REG_LAST_LEGAL = 3'h5;
    localparam int DATA_W = 8;
    localparam int CLOCK_MHZ = 125;
    // ----------------------------------------
    // bus timing in ns, slowest speed grade
    // ----------------------------------------
    localparam int WRITE_ACTIVE_NS = 420;
    localparam int ACCESS_NS = 450;
    localparam int CYCLE_NS = 450;
    localparam int SETUP_NS = 8;
    localparam int SYNC_STAGES = 2;
    localparam int WRITE_ACTIVE_CYC = (WRITE_ACTIVE_NS * CLOCK_MHZ + 999) / 1000;
    localparam int ACCESS_CYC = (ACCESS_NS * CLOCK_MHZ + 999) / 1000;
    localparam int CYCLE_CYC = (CYCLE_NS * CLOCK_MHZ + 999) / 1000;
    localparam int SETUP_CYC = (SETUP_NS * CLOCK_MHZ + 999) / 1000;
    localparam int CNT_W = 8;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_ACTIVE = 3'b010,
        ST_HOLD = 3'b011,
        ST_RECOVER = 3'b100
    } bus_state_t;
endpackage : port_ctrl_pkg

// ==== verification/port_device_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module port_device_model #(
    parameter int ACC_NS = 270
) (
    input wire logic chip_select_n,
    input wire logic read_write,
    input wire logic [2:0] register_select,
    input wire logic [7:0] bus_level,
    input wire logic reset_n,
    input wire logic [23:0] ext_pins,
    output logic [23:0] pin_level,
    output logic [7:0] bus_out,
    output logic bus_oe
);
    logic [7:0] regs [6];
    logic [7:0] rd_value;
    logic write_on;
    // ----------------------------------------
    // register storage
    // ----------------------------------------
    // the write window is both lines low; data is taken as it closes
    assign write_on = !chip_select_n && !read_write;
    always @(negedge write_on or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 6; i++) regs[i] = 8'h00;
        end else if (register_select < 3'h6) begin
            regs[register_select] = bus_level;
        end
    end
    // ----------------------------------------
    // pins and read path
    // ----------------------------------------
    // each pin picks its own data bit or the outside level
    always_comb begin
        for (int p = 0; p < 3; p++) begin
            for (int b = 0; b < 8; b++) begin
                pin_level[p*8+b] = regs[p+3][b] ? regs[p][b] : ext_pins[p*8+b];
            end
        end
    end
    // illegal codes give a fixed junk pattern, not a register
    always_comb begin
        rd_value = 8'h3C;
        if (register_select < 3'h3) begin
            rd_value = pin_level[int'(register_select)*8 +: 8];
        end else if (register_select < 3'h6) begin
            rd_value = regs[register_select];
        end
    end
    assign bus_oe = !chip_select_n && read_write;
    // slow device: read data settles late in the access
    assign #(ACC_NS) bus_out = rd_value;
endmodule : port_device_model
`default_nettype wire

// ==== verification/port_bus_host_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module port_bus_host_bench;
    import port_ctrl_pkg::*;
    logic clock = 0;
    logic rst = 1;
    logic req_valid = 0;
    logic req_write = 0;
    logic [2:0] req_reg = 3'h0;
    logic [7:0] req_wdata = 8'h00;
    logic req_ready, rsp_valid, rsp_error, chip_select_n, read_write, host_oe, dev_oe, reset_n;
    logic [7:0] rsp_rdata, host_out, dev_out, rd;
    logic [2:0] register_select;
    logic [23:0] ext_pins = 24'h5AC396;
    logic [23:0] pin_level;
    logic [7:0] last_bus = 8'h00;
    logic [7:0] dv [3] = '{8'hA5, 8'h3C, 8'hF0};
    logic [7:0] dm [3] = '{8'h0F, 8'hFF, 8'h81};
    logic er;
    int error_cnt = 0;
    int compares = 0;
    // a bus nobody drives shows the inverse of its last level
    wire logic [7:0] bus_level = host_oe ? host_out : (dev_oe ? dev_out : ~last_bus);
    always @(posedge clock) if (host_oe || dev_oe) last_bus <= bus_level;
    initial forever #4 clock = ~clock;
    port_bus_host dut (.clock(clock), .rst(rst), .req_valid(req_valid), .req_write(req_write),
        .req_reg(req_reg), .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_error(rsp_error), .rsp_rdata(rsp_rdata), .chip_select_n(chip_select_n),
        .read_write(read_write), .register_select(register_select), .host_data_bus_out(host_out),
        .host_data_bus_oe(host_oe), .host_data_bus_in(bus_level), .reset_n(reset_n));
    // the model answers only a full access time after the select settles
    port_device_model #(.ACC_NS(ACCESS_NS)) dev (.chip_select_n(chip_select_n),
        .read_write(read_write), .register_select(register_select), .bus_level(bus_level),
        .reset_n(reset_n), .ext_pins(ext_pins), .pin_level(pin_level), .bus_out(dev_out),
        .bus_oe(dev_oe));
    // ----------------------------------------
    // access and compare tasks
    // ----------------------------------------
    task automatic access(input logic wr, input logic [2:0] rg, input logic [7:0] wd);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 300) begin
            @(negedge clock);
            n++;
        end
        req_valid = 1;
        req_write = wr;
        req_reg = rg;
        req_wdata = wd;
        @(negedge clock);
        req_valid = 0;
        while (rsp_valid !== 1'b1 && n < 600) begin
            @(negedge clock);
            n++;
        end
        if (rsp_valid !== 1'b1) begin
            error_cnt++;
            $display("CHECK FAILED rsp_valid expected 1 seen %b", rsp_valid);
        end
        rd = rsp_rdata;
        er = rsp_error;
    endtask : access
    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic stop_test();
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test
    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(negedge clock);
        rst = 0;
        repeat (2) @(negedge clock);
        check("pins after reset", ext_pins, pin_level);
        for (int r = 0; r < 6; r++) begin
            access(0, 3'(r), 8'h00);
            check("read after reset", (r < 3) ? 24'(ext_pins[r*8 +: 8]) : 24'h0, 24'(rd));
        end
        // data first, then direction, so no stray level shows
        for (int r = 0; r < 3; r++) begin
            access(1, 3'(r), dv[r]);
            access(1, 3'(r + 3), dm[r]);
            access(0, 3'(r + 3), 8'h00);
            check("direction readback", 24'(dm[r]), 24'(rd));
            access(0, 3'(r), 8'h00);
            check("data read", 24'((dv[r] & dm[r]) | (ext_pins[r*8 +: 8] & ~dm[r])), 24'(rd));
            check("pins", 24'((dv[r] & dm[r]) | (ext_pins[r*8 +: 8] & ~dm[r])), 24'(pin_level[r*8 +: 8]));
        end
        // outside levels move: inputs follow, outputs hold
        ext_pins = ~ext_pins;
        access(0, 3'h0, 8'h00);
        check("sensed after change", 24'((8'hA5 & 8'h0F) | (ext_pins[7:0] & 8'hF0)), 24'(rd));
        access(1, 3'h6, 8'hFF);
        check("illegal write flagged", 24'h1, 24'(er));
        access(0, 3'h7, 8'h00);
        check("illegal read flagged", 24'h1, 24'(er));
        access(0, 3'h5, 8'h00);
        check("no stray write", 24'h81, 24'(rd));
        check("legal read not flagged", 24'h0, 24'(er));
        rst = 1;
        repeat (20) @(negedge clock);
        rst = 0;
        repeat (2) @(negedge clock);
        check("pins after second reset", ext_pins, pin_level);
        stop_test();
    end
    // a hung handshake is cut off well past the expected run length
    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        stop_test();
    end
endmodule : port_bus_host_bench
`default_nettype wire
